// ---- shared/emi_defs.svh ----
// Constants of the external memory bus interface
`ifndef EMI_DEFS_SVH
`define EMI_DEFS_SVH
// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define EMI_OFS_CTRL_A      12'h000
`define EMI_OFS_CTRL_B      12'h004
`define EMI_OFS_STATUS      12'h008
`define EMI_CTRL_A_RESET    8'h00
`define EMI_CTRL_B_RESET    8'h00
// Control A fields
`define EMI_A_EN_BIT        7
`define EMI_A_SECT_HI       6
`define EMI_A_SECT_LO       4
`define EMI_A_WU_HI         3
`define EMI_A_WU_LO         2
`define EMI_A_WL_HI         1
`define EMI_A_WL_LO         0
// Control B fields
`define EMI_B_KEEP_BIT      7
`define EMI_B_MASK_HI       2
`define EMI_B_MASK_LO       0
// ----------------------------------------------------------------
// Memory map
// ----------------------------------------------------------------
`define EMI_INT_TOP         16'h21FF
`define EMI_SECT_UNIT_SH    13
`define EMI_APB_LAST        12'hFFF
`endif

// ---- shared/emi_pkg.sv ----
// Types of the external memory bus interface
package emi_pkg;
   typedef enum logic [2:0] {
      EMI_IDLE,
      EMI_ADDR,
      EMI_WAIT,
      EMI_DATA,
      EMI_DONE
   } emi_state_e;
   typedef logic [7:0]  emi_byte_t;
   typedef logic [15:0] emi_addr_t;
endpackage

// ---- hdl/emi_keeper.sv ----
// Bus keeper for the multiplexed address/data lines
`timescale 1ns/1ns
module emi_keeper (
   input  wire logic           core_clk_i,
   input  wire logic           resetn_i,
   input  wire logic           keep_en_i,
   input  wire logic           drive_i,
   input  wire emi_pkg::emi_byte_t drv_data_i,
   input  wire emi_pkg::emi_byte_t pin_sync_i,
   output emi_pkg::emi_byte_t  held_o,
   output logic                hold_o
);
   import emi_pkg::*;
   // ----------------------------------------------------------------
   // Last driven value
   // ----------------------------------------------------------------
   emi_byte_t last;
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         last <= 8'h00;
      end else if (drive_i) begin
         last <= drv_data_i;
      end else if (!keep_en_i) begin
         // Track floating level so a later enable holds what is seen
         last <= pin_sync_i;
      end
   end
   assign held_o = last;
   assign hold_o = keep_en_i && !drive_i;
endmodule // emi_keeper

// ---- hdl/emi_ext_mem_interface.sv ----
// External memory bus interface with APB control registers
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "emi_defs.svh"
module emi_ext_mem_interface (
   input  wire logic               core_clk_i,
   input  wire logic               resetn_i,
   // APB slave
   input  wire logic               psel_i,
   input  wire logic               penable_i,
   input  wire logic               pwrite_i,
   input  wire logic [11:0]        paddr_i,
   input  wire logic [31:0]        pwdata_i,
   output logic [31:0]             prdata_o,
   output logic                    pready_o,
   output logic                    pslverr_o,
   // CPU data-space port
   input  wire logic               cpu_req_i,
   input  wire logic               cpu_we_i,
   input  wire emi_pkg::emi_addr_t cpu_addr_i,
   input  wire emi_pkg::emi_byte_t cpu_wdata_i,
   output logic                    cpu_ext_o,
   output logic                    cpu_busy_o,
   output logic                    cpu_done_o,
   output emi_pkg::emi_byte_t      cpu_rdata_o,
   // Port values and directions from the GPIO block
   input  wire emi_pkg::emi_byte_t port_lo_out_i,
   input  wire emi_pkg::emi_byte_t port_lo_dir_i,
   input  wire emi_pkg::emi_byte_t port_hi_out_i,
   input  wire emi_pkg::emi_byte_t port_hi_dir_i,
   input  wire logic [1:0]         port_st_out_i,
   input  wire logic [1:0]         port_st_dir_i,
   // Pins
   input  wire emi_pkg::emi_byte_t muxed_addr_data_bus_i,
   output emi_pkg::emi_byte_t      muxed_addr_data_bus_o,
   output emi_pkg::emi_byte_t      muxed_addr_data_bus_oe_n_o,
   output emi_pkg::emi_byte_t      high_addr_bus_o,
   output emi_pkg::emi_byte_t      high_addr_bus_oe_n_o,
   output logic                    addr_latch_o,
   output logic                    rd_n_o,
   output logic                    wr_n_o,
   output logic                    strobe_oe_n_o
);
   import emi_pkg::*;
   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   emi_byte_t ext_mem_ctrl_a;
   emi_byte_t ext_mem_ctrl_b;
   logic      wr_acc;
   assign wr_acc = psel_i && penable_i && pwrite_i;
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ext_mem_ctrl_a <= `EMI_CTRL_A_RESET;
      end else if (wr_acc && paddr_i == `EMI_OFS_CTRL_A) begin
         ext_mem_ctrl_a <= pwdata_i[7:0];
      end
   end
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ext_mem_ctrl_b <= `EMI_CTRL_B_RESET;
      end else if (wr_acc && paddr_i == `EMI_OFS_CTRL_B) begin
         ext_mem_ctrl_b <= pwdata_i[7:0];
      end
   end
   logic       ext_mem_enable_bit;
   logic [2:0] sect_sel;
   logic [1:0] wait_lo;
   logic [1:0] wait_hi;
   logic       keep_en;
   logic [2:0] addr_mask;
   assign ext_mem_enable_bit = ext_mem_ctrl_a[`EMI_A_EN_BIT];
   assign sect_sel  = ext_mem_ctrl_a[`EMI_A_SECT_HI:`EMI_A_SECT_LO];
   assign wait_hi   = ext_mem_ctrl_a[`EMI_A_WU_HI:`EMI_A_WU_LO];
   assign wait_lo   = ext_mem_ctrl_a[`EMI_A_WL_HI:`EMI_A_WL_LO];
   assign keep_en   = ext_mem_ctrl_b[`EMI_B_KEEP_BIT];
   assign addr_mask = ext_mem_ctrl_b[`EMI_B_MASK_HI:`EMI_B_MASK_LO];
   // ----------------------------------------------------------------
   // Pin input synchroniser
   // ----------------------------------------------------------------
   emi_byte_t ad_meta;
   emi_byte_t ad_sync;
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ad_meta <= 8'h00;
         ad_sync <= 8'h00;
      end else begin
         ad_meta <= muxed_addr_data_bus_i;
         ad_sync <= ad_meta;
      end
   end
   // ----------------------------------------------------------------
   // Access decode
   // ----------------------------------------------------------------
   emi_state_e state;
   emi_addr_t  acc_addr;
   emi_byte_t  acc_wdata;
   logic       acc_we;
   logic       acc_ext;
   logic [1:0] wait_cnt;
   logic       req_ext;
   logic       upper_sect;
   logic [1:0] req_wait;
   // Whole space treated as one sector when selector is zero
   assign req_ext = ext_mem_enable_bit && (cpu_addr_i > `EMI_INT_TOP);
   assign upper_sect = (sect_sel != 3'h0) &&
                       (cpu_addr_i[15:`EMI_SECT_UNIT_SH] >= sect_sel);
   assign req_wait = upper_sect ? wait_hi : wait_lo;
   assign cpu_ext_o = req_ext;
   // ----------------------------------------------------------------
   // Access sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state     <= EMI_IDLE;
         acc_addr  <= 16'h0000;
         acc_wdata <= 8'h00;
         acc_we    <= 1'b0;
         acc_ext   <= 1'b0;
         wait_cnt  <= 2'h0;
      end else begin
         case (state)
            EMI_IDLE: begin
               if (cpu_req_i && ext_mem_enable_bit) begin
                  state     <= EMI_ADDR;
                  acc_addr  <= cpu_addr_i;
                  acc_wdata <= cpu_wdata_i;
                  acc_we    <= cpu_we_i;
                  acc_ext   <= req_ext;
                  wait_cnt  <= req_wait;
               end
            end
            EMI_ADDR: begin
               // Internal accesses finish here; the address still shows on pins
               if (!acc_ext) begin
                  state <= EMI_IDLE;
               end else if (wait_cnt != 2'h0) begin
                  state <= EMI_WAIT;
               end else begin
                  state <= EMI_DATA;
               end
            end
            EMI_WAIT: begin
               wait_cnt <= wait_cnt - 2'h1;
               if (wait_cnt == 2'h1) begin
                  state <= EMI_DATA;
               end
            end
            EMI_DATA: begin
               state <= EMI_DONE;
            end
            EMI_DONE: begin
               state <= EMI_IDLE;
            end
            default: begin
               state <= EMI_IDLE;
            end
         endcase
      end
   end
   // ----------------------------------------------------------------
   // Read data capture
   // ----------------------------------------------------------------
   // Pins reach ad_sync two edges late, so capture one edge after DONE
   logic fin_q;
   logic done_q;
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cpu_rdata_o <= 8'h00;
      end else if (fin_q && !acc_we) begin
         cpu_rdata_o <= ad_sync;
      end
   end
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fin_q  <= 1'b0;
         done_q <= 1'b0;
      end else begin
         fin_q  <= (state == EMI_DONE);
         done_q <= fin_q || (state == EMI_ADDR && !acc_ext);
      end
   end
   assign cpu_done_o = done_q;
   assign cpu_busy_o = (state != EMI_IDLE);
   // ----------------------------------------------------------------
   // Pin outputs
   // ----------------------------------------------------------------
   logic      active;
   logic      in_data;
   logic      drv_ad;
   logic      strobe_ok;
   emi_byte_t bus_val;
   emi_byte_t held;
   logic      hold;
   assign active    = (state != EMI_IDLE);
   assign in_data   = (state == EMI_WAIT) || (state == EMI_DATA) || (state == EMI_DONE);
   assign strobe_ok = acc_ext && in_data && (state != EMI_DONE);
   // Address driven in address phase; write data driven in data phase
   assign drv_ad  = ext_mem_enable_bit && active &&
                    ((state == EMI_ADDR) || acc_we);
   assign bus_val = (state == EMI_ADDR) ? acc_addr[7:0] : acc_wdata;
   logic      next_rd_stb;
   assign next_rd_stb = ext_mem_enable_bit && acc_ext &&
                        ((state == EMI_ADDR) || (strobe_ok && state != EMI_DATA));
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         addr_latch_o <= 1'b0;
         rd_n_o       <= 1'b1;
         wr_n_o       <= 1'b1;
      end else begin
         // Latch strobe high at address setup, low through the data phase
         addr_latch_o <= (state == EMI_IDLE) && cpu_req_i && ext_mem_enable_bit;
         rd_n_o <= !((next_rd_stb) && !acc_we);
         wr_n_o <= !((next_rd_stb) && acc_we);
      end
   end
   emi_keeper i_emi_keeper (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .keep_en_i  (keep_en),
      .drive_i    (drv_ad),
      .drv_data_i (bus_val),
      .pin_sync_i (ad_sync),
      .held_o     (held),
      .hold_o     (hold)
   );
   // ----------------------------------------------------------------
   // Port override
   // ----------------------------------------------------------------
   emi_byte_t hi_claim;
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_hi
         // Mask n releases the top n pins; seven releases the whole byte
         assign hi_claim[gi] = ext_mem_enable_bit && (addr_mask != 3'h7) &&
                               (4'(gi) < (4'h8 - {1'b0, addr_mask}));
         assign high_addr_bus_o[gi] = hi_claim[gi] ? acc_addr[8 + gi]
                                                   : port_hi_out_i[gi];
         assign high_addr_bus_oe_n_o[gi] = hi_claim[gi] ? 1'b0 : !port_hi_dir_i[gi];
      end
   endgenerate
   always_comb begin
      if (!ext_mem_enable_bit) begin
         muxed_addr_data_bus_o      = port_lo_out_i;
         muxed_addr_data_bus_oe_n_o = ~port_lo_dir_i;
      end else if (drv_ad) begin
         muxed_addr_data_bus_o      = bus_val;
         muxed_addr_data_bus_oe_n_o = 8'h00;
      end else if (hold && !(acc_ext && in_data && !acc_we)) begin
         muxed_addr_data_bus_o      = held;
         muxed_addr_data_bus_oe_n_o = 8'h00;
      end else begin
         muxed_addr_data_bus_o      = held;
         muxed_addr_data_bus_oe_n_o = 8'hFF;
      end
   end
   assign strobe_oe_n_o = ext_mem_enable_bit ? 1'b0 : !(&port_st_dir_i);
   // Port values of strobe pins handled outside while disabled
   logic unused_st;
   assign unused_st = ^port_st_out_i;
   // ----------------------------------------------------------------
   // APB read side
   // ----------------------------------------------------------------
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i && penable_i && (paddr_i > `EMI_OFS_STATUS);
   always_comb begin
      case (paddr_i)
         `EMI_OFS_CTRL_A: prdata_o = {24'h000000, ext_mem_ctrl_a};
         `EMI_OFS_CTRL_B: prdata_o = {24'h000000, ext_mem_ctrl_b};
         `EMI_OFS_STATUS: prdata_o = {28'h0000000, acc_ext, acc_we, cpu_busy_o, unused_st};
         default:         prdata_o = 32'h00000000;
      endcase
   end
endmodule // emi_ext_mem_interface

// ---- bench/emi_ext_mem_interface_chk.sv ----
// Port-level assertions for the external memory bus interface
`timescale 1ns/1ns
`include "emi_defs.svh"
module emi_ext_mem_interface_chk
   import emi_pkg::*;
(
   input wire logic               core_clk_i,
   input wire logic               resetn_i,
   input wire logic               psel_i,
   input wire logic               penable_i,
   input wire logic               pwrite_i,
   input wire logic [11:0]        paddr_i,
   input wire logic [31:0]        pwdata_i,
   input wire logic               cpu_req_i,
   input wire emi_pkg::emi_addr_t cpu_addr_i,
   input wire emi_pkg::emi_byte_t cpu_wdata_i,
   input wire logic               cpu_ext_o,
   input wire logic               cpu_busy_o,
   input wire logic               cpu_done_o,
   input wire emi_pkg::emi_byte_t port_lo_out_i,
   input wire emi_pkg::emi_byte_t port_lo_dir_i,
   input wire emi_pkg::emi_byte_t muxed_addr_data_bus_o,
   input wire emi_pkg::emi_byte_t muxed_addr_data_bus_oe_n_o,
   input wire logic               addr_latch_o,
   input wire logic               rd_n_o,
   input wire logic               wr_n_o,
   input wire logic               strobe_oe_n_o
);
   // ---------------------------------------------
   // Shadow of control A and access bookkeeping
   // ---------------------------------------------
   logic [7:0] ctl_a, la, wd;
   logic [3:0] cnt, lat;
   logic [1:0] w;
   logic       take;
   assign take = cpu_req_i && !cpu_busy_o && ctl_a[7];
   assign w = (ctl_a[6:4] != 3'h0 && cpu_addr_i[15:13] >= ctl_a[6:4]) ? ctl_a[3:2] : ctl_a[1:0];
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i)
         ctl_a <= 8'h00;
      else if (psel_i && penable_i && pwrite_i && paddr_i == 12'h000)
         ctl_a <= pwdata_i[7:0];
   end
   // Latency expected as count of edges after the take
   always_ff @(posedge core_clk_i) begin
      if (take) begin
         cnt <= 4'h0;
         lat <= cpu_ext_o ? 4'h4 + {2'h0, w} : 4'h1;
         la  <= cpu_addr_i[7:0];
         wd  <= cpu_wdata_i;
      end else if (cnt != 4'hF)
         cnt <= cnt + 4'h1;
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   sequence s_int_take; take && !cpu_ext_o; endsequence
   sequence s_ext_take; take && cpu_ext_o; endsequence
   property p_excl; rd_n_o || wr_n_o; endproperty
   property p_ale_low; !rd_n_o || !wr_n_o |-> !addr_latch_o; endproperty
   property p_int_quiet; s_int_take |-> (rd_n_o && wr_n_o) [*3]; endproperty
   property p_addr; s_ext_take |=> addr_latch_o && muxed_addr_data_bus_oe_n_o == 8'h00
      && muxed_addr_data_bus_o == la; endproperty
   property p_lat; cpu_done_o |-> cnt == lat; endproperty
   property p_bound; take |-> ##[1:8] cpu_done_o; endproperty
   property p_wdata; !wr_n_o |-> muxed_addr_data_bus_oe_n_o == 8'h00
      && muxed_addr_data_bus_o == wd; endproperty
   property p_decode; cpu_ext_o == (ctl_a[7] && cpu_addr_i > `EMI_INT_TOP); endproperty
   property p_off; cpu_req_i && !ctl_a[7] |=> !cpu_busy_o; endproperty
   property p_pins; !ctl_a[7] |-> muxed_addr_data_bus_o == port_lo_out_i
      && muxed_addr_data_bus_oe_n_o == ~port_lo_dir_i; endproperty
   property p_own; ctl_a[7] |-> !strobe_oe_n_o; endproperty
   a_excl: assert property (p_excl) else $error("both strobes low");
   a_ale_low: assert property (p_ale_low) else $error("latch strobe high in data phase");
   a_int_quiet: assert property (p_int_quiet) else $error("strobe on internal access");
   a_addr: assert property (p_addr) else $error("low address not on bus");
   a_lat: assert property (p_lat) else $error("access latency wrong");
   a_bound: assert property (p_bound) else $error("access never completed");
   a_wdata: assert property (p_wdata) else $error("write data not on bus");
   a_decode: assert property (p_decode) else $error("decode wrong");
   a_off: assert property (p_off) else $error("request taken while disabled");
   a_pins: assert property (p_pins) else $error("pins not on port setting");
   a_own: assert property (p_own) else $error("strobe pins not owned");
endmodule // emi_ext_mem_interface_chk

bind emi_ext_mem_interface emi_ext_mem_interface_chk i_emi_ext_mem_interface_chk (.*);

// ---- bench/emi_sram_model.sv ----
// External byte memory behind a transparent address latch
`timescale 1ns/1ns
module emi_sram_model
   import emi_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic               ale_i,
   input  wire logic               rd_n_i,
   input  wire logic               wr_n_i,
   input  wire emi_pkg::emi_byte_t ad_i,
   input  wire emi_pkg::emi_byte_t hi_i,
   output emi_pkg::emi_byte_t      d_o,
   output logic                    oe_o
);
   emi_byte_t lat_q;
   emi_byte_t mem [0:65535];
   always_latch begin
      if (ale_i)
         lat_q <= ad_i;
   end
   always @(posedge clk_i) begin
      if (!wr_n_i)
         mem[{hi_i, lat_q}] <= ad_i;
   end
   // Released as soon as the strobe rises, no hold time granted
   assign oe_o = !rd_n_i;
   assign d_o  = mem[{hi_i, lat_q}];
endmodule // emi_sram_model

// ---- bench/emi_ext_mem_interface_tb.sv ----
// Self-checking testbench of the external memory bus interface
`timescale 1ns/1ns
module emi_ext_mem_interface_tb;
   import emi_pkg::*;
   logic        core_clk_i, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, err;
   logic        cpu_req_i = 0, cpu_we_i = 0, pready_o, pslverr_o, cpu_ext_o, moe;
   logic        cpu_busy_o, cpu_done_o, addr_latch_o, rd_n_o, wr_n_o, strobe_oe_n_o;
   logic [11:0] paddr_i = 0;
   logic [31:0] pwdata_i = 0, prdata_o, r;
   logic [1:0]  port_st_out_i = 2'h3, port_st_dir_i = 2'h3;
   emi_addr_t   cpu_addr_i = 0;
   emi_byte_t   cpu_wdata_i = 0, port_lo_out_i = 8'hA5, port_lo_dir_i = 8'h0F;
   emi_byte_t   port_hi_out_i = 8'h3C, port_hi_dir_i = 8'h0F, last_q = 8'h00, md;
   emi_byte_t   cpu_rdata_o, muxed_addr_data_bus_i, muxed_addr_data_bus_o;
   emi_byte_t   muxed_addr_data_bus_oe_n_o, high_addr_bus_o, high_addr_bus_oe_n_o;
   int          failures = 0, checked = 0, cyc = 0, n;
   emi_ext_mem_interface i_emi_ext_mem_interface (.*);
   emi_sram_model i_emi_sram_model (
      .clk_i  (core_clk_i),
      .ale_i  (addr_latch_o),
      .rd_n_i (rd_n_o),
      .wr_n_i (wr_n_o),
      .ad_i   (muxed_addr_data_bus_i),
      .hi_i   (high_addr_bus_o),
      .d_o    (md),
      .oe_o   (moe)
   );
   // Undriven lines flip each cycle so a stale value never reads as valid
   assign muxed_addr_data_bus_i = (~muxed_addr_data_bus_oe_n_o & muxed_addr_data_bus_o)
      | (muxed_addr_data_bus_oe_n_o & (moe ? md : ~last_q));
   always @(posedge core_clk_i) last_q <= muxed_addr_data_bus_i;
   initial begin
      core_clk_i = 0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic test_done();
      if (failures == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      psel_i <= 1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge core_clk_i);
      penable_i <= 1;
      do @(posedge core_clk_i); while (pready_o !== 1'b1);
      r = prdata_o;
      err = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
   endtask
   task automatic cpu(input logic w, input emi_addr_t a, input emi_byte_t d);
      @(posedge core_clk_i);
      cpu_req_i <= 1;
      cpu_we_i <= w;
      cpu_addr_i <= a;
      cpu_wdata_i <= d;
      @(posedge core_clk_i);
      cpu_req_i <= 0;
      n = 0;
      do begin
         @(posedge core_clk_i);
         #1;
         n++;
      end while (cpu_done_o !== 1'b1 && n < 20);
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_regs();
      apb(0, 12'h000, 0);
      chk(r, 0);
      apb(1, 12'h004, 32'h03);
      apb(0, 12'h004, 0);
      chk(r[7:0], 8'h03);
      apb(0, 12'h00C, 0);
      chk(err, 1);
      apb(1, 12'h004, 0);
   endtask
   task automatic t_off();
      cpu(1, 16'h4000, 8'h77);
      chk(n, 20);
      chk(cpu_ext_o, 0);
      chk(muxed_addr_data_bus_oe_n_o, 8'(~port_lo_dir_i));
   endtask
   task automatic t_waits();
      for (int w = 0; w < 4; w++) begin
         apb(1, 12'h000, 32'h80 | (w << 2) | w);
         cpu(1, 16'h2200 + 16'(w), 8'hA0 + 8'(w));
         chk(n, 4 + w);
         cpu(0, 16'h2200 + 16'(w), 8'h00);
         chk(n, 4 + w);
         chk(cpu_rdata_o, 8'hA0 + 8'(w));
      end
      cpu(0, 16'h21FF, 8'h00);
      chk(n, 1);
   endtask
   task automatic t_sector();
      apb(1, 12'h000, 32'hAC);
      cpu(1, 16'h3FFF, 8'h01);
      chk(n, 4);
      cpu(1, 16'h4000, 8'h02);
      chk(n, 7);
   endtask
   task automatic t_high_keep();
      apb(1, 12'h004, 32'h04);
      @(posedge core_clk_i);
      #1;
      chk(high_addr_bus_oe_n_o, {~port_hi_dir_i[7:4], 4'h0});
      chk(high_addr_bus_o, {port_hi_out_i[7:4], 4'h0});
      apb(1, 12'h004, 32'h80);
      cpu(1, 16'h2345, 8'h5A);
      repeat (2) @(posedge core_clk_i);
      #1;
      chk(muxed_addr_data_bus_o, 8'h5A);
      chk(muxed_addr_data_bus_oe_n_o, 8'h00);
   endtask
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         $display("[ERR] %0t run too long", $time);
         test_done();
      end
   end
   initial begin
      repeat (10) @(posedge core_clk_i);
      resetn_i <= 1;
      t_regs();
      t_off();
      t_waits();
      t_sector();
      t_high_keep();
      test_done();
   end
endmodule // emi_ext_mem_interface_tb
